// ### verilog/eeac_regs.svh
`ifndef EEAC_REGS_SVH
`define EEAC_REGS_SVH

// Register byte offsets on the APB bus.
`define EEAC_OFF_CTRL 8'h00
`define EEAC_OFF_ADDR 8'h04
`define EEAC_OFF_DATA 8'h08
`define EEAC_OFF_STATUS 8'h0C
`define EEAC_OFF_MASK 8'h10

// Control register fields.
`define EEAC_CTRL_RD_BIT 0
`define EEAC_CTRL_WR_BIT 1
`define EEAC_CTRL_ARM_BIT 2
`define EEAC_CTRL_SPM_BIT 3

// Reset values.
`define EEAC_RST_ADDR 16'h0000
`define EEAC_RST_DATA 8'h00
`define EEAC_RST_EVENTS 3'h0

// Timing in mclk cycles, and write time in oscillator cycles.
`define EEAC_ARM_WINDOW 3'h4
`define EEAC_STALL_WR 3'h2
`define EEAC_STALL_RD 3'h4
`define EEAC_WRITE_OSC_CYCLES 67584
// Typical write time that the oscillator count gives, for reference only.
`define EEAC_WRITE_TYP_US 8500

`endif

// ### verilog/eeac_pkg.sv
package eeac_pkg;

	typedef enum {
		EEAC_IDLE,
		EEAC_PROG
	} eeac_state_e;

	// Sticky event flags; status and mask share this layout.
	typedef struct packed {
		logic wr_fail;
		logic rd_done;
		logic wr_done;
	} eeac_events_s;

endpackage

// ### verilog/eeac_top.sv
// Functional notes
// - Write strobe sits at control bit 1, read strobe at bit 0.
// - A write starts only if strobe is set while master arm is already set.
// - Strobe must follow arming within four cycles; arm times out after.
// - A strobe after the arm timed out abandons the write.
// - No EEPROM programming while self-programming of flash is busy.
// - Hardware clears the write strobe when the write time has elapsed.
// - Setting the write strobe stalls the CPU for two cycles.
// - A read strobe loads the addressed byte into the data register at once.
// - Setting the read strobe stalls the CPU for four cycles.
// - During a write, reads are ignored and the address is frozen.
// - A write lasts 67584 calibrated oscillator cycles.
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/100ps
`include "eeac_regs.svh"

module eeac_top #(
	parameter int ADDR_W = 9,
	parameter int WRITE_OSC_CYCLES = `EEAC_WRITE_OSC_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Flash interlock and write timing
	input wire logic self_program_busy,
	input wire logic rc_osc_clk,
	// CPU side
	output logic cpu_stall,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	localparam int PCNT_W = $clog2(WRITE_OSC_CYCLES + 1);
	localparam int DEPTH = 1 << ADDR_W;
	localparam logic [PCNT_W-1:0] PCNT_LAST = PCNT_W'(WRITE_OSC_CYCLES - 1);

	generate
		if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr
			$error("eeac_top: ADDR_W must lie between 1 and 16");
		end
		if (WRITE_OSC_CYCLES < 2) begin : g_bad_count
			$error("eeac_top: WRITE_OSC_CYCLES must be at least 2");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	logic [7:0] mem [DEPTH];

	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic cpu_stall_reg;
	logic irq_reg;

	logic [ADDR_W-1:0] addr_reg;
	logic [7:0] data_reg;
	logic [7:0] wr_data_reg;
	logic [2:0] arm_cnt_reg;
	logic [2:0] arm_cnt_next;
	logic [2:0] stall_reg;
	logic [2:0] stall_next;
	logic [PCNT_W-1:0] prog_cnt_reg;
	eeac_pkg::eeac_state_e state_reg;
	eeac_pkg::eeac_events_s status_reg;
	eeac_pkg::eeac_events_s status_next;
	eeac_pkg::eeac_events_s mask_reg;
	eeac_pkg::eeac_events_s events;

	logic spm_meta_reg;
	logic spm_sync_reg;
	logic osc_meta_reg;
	logic osc_sync_reg;
	logic osc_prev_reg;

	////////////////////////////////////////////////////////////////////////
	// Bus decode.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	wire access = psel & penable & pready_reg;
	wire wr_acc = access & pwrite;
	wire rd_acc = access & ~pwrite;
	wire sel_ctrl = hit(paddr, `EEAC_OFF_CTRL);
	wire sel_addr = hit(paddr, `EEAC_OFF_ADDR);
	wire sel_data = hit(paddr, `EEAC_OFF_DATA);
	wire sel_status = hit(paddr, `EEAC_OFF_STATUS);
	wire sel_mask = hit(paddr, `EEAC_OFF_MASK);
	wire mapped = sel_ctrl | sel_addr | sel_data | sel_status | sel_mask;
	wire ctrl_wr = wr_acc & sel_ctrl;

	wire busy = (state_reg == eeac_pkg::EEAC_PROG);
	wire arm_active = (arm_cnt_reg != 3'h0);
	wire osc_tick = osc_sync_reg & ~osc_prev_reg;
	wire prog_last = busy & osc_tick & (prog_cnt_reg == PCNT_LAST);
	wire [7:0] rd_byte = mem[addr_reg];

	wire wr_strobe_in = pwdata[`EEAC_CTRL_WR_BIT];
	wire rd_strobe_in = pwdata[`EEAC_CTRL_RD_BIT];
	wire arm_in = pwdata[`EEAC_CTRL_ARM_BIT];

	wire wr_go = ctrl_wr & wr_strobe_in & arm_active & ~busy & ~spm_sync_reg;
	wire wr_reject = ctrl_wr & wr_strobe_in & ~wr_go & ~busy;
	wire rd_go = ctrl_wr & rd_strobe_in & ~wr_strobe_in & ~busy;
	wire addr_we = wr_acc & sel_addr & ~busy;
	wire arm_set = ctrl_wr & arm_in & ~wr_strobe_in;

	wire [31:0] ctrl_view = {28'h0000000, spm_sync_reg, arm_active, busy, 1'b0};
	wire [31:0] rdata_mux =
		sel_ctrl ? ctrl_view :
		sel_addr ? {{(32 - ADDR_W){1'b0}}, addr_reg} :
		sel_data ? {24'h000000, data_reg} :
		sel_status ? {29'h0000000, status_reg} :
		sel_mask ? {29'h0000000, mask_reg} : 32'h00000000;

	////////////////////////////////////////////////////////////////////////
	// Arming window and stall counters.
	always_comb begin
		if (arm_set) begin
			arm_cnt_next = `EEAC_ARM_WINDOW;
		end else if (ctrl_wr & wr_strobe_in) begin
			arm_cnt_next = 3'h0;
		end else if (arm_active) begin
			arm_cnt_next = arm_cnt_reg - 3'h1;
		end else begin
			arm_cnt_next = 3'h0;
		end
	end

	always_comb begin
		if (wr_go) begin
			stall_next = `EEAC_STALL_WR;
		end else if (rd_go) begin
			stall_next = `EEAC_STALL_RD;
		end else if (stall_reg != 3'h0) begin
			stall_next = stall_reg - 3'h1;
		end else begin
			stall_next = 3'h0;
		end
	end

	// A set in the same cycle as a status read wins over the clear.
	assign events = '{wr_fail: wr_reject, rd_done: rd_go, wr_done: prog_last};
	assign status_next = (rd_acc & sel_status) ? events : (status_reg | events);

	////////////////////////////////////////////////////////////////////////
	// Synchronisers for the flash busy level and the oscillator.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			spm_meta_reg <= 1'b0;
			spm_sync_reg <= 1'b0;
			osc_meta_reg <= 1'b0;
			osc_sync_reg <= 1'b0;
			osc_prev_reg <= 1'b0;
		end else begin
			spm_meta_reg <= self_program_busy;
			spm_sync_reg <= spm_meta_reg;
			osc_meta_reg <= rc_osc_clk;
			osc_sync_reg <= osc_meta_reg;
			osc_prev_reg <= osc_sync_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB answer: one wait state, held off further while the CPU is stalled.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else begin
			pready_reg <= psel & penable & ~pready_reg & (stall_reg == 3'h0);
			pslverr_reg <= psel & penable & ~pready_reg & (stall_reg == 3'h0) & ~mapped;
			prdata_reg <= rdata_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write sequencer, timed by the calibrated oscillator.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_reg <= eeac_pkg::EEAC_IDLE;
			prog_cnt_reg <= '0;
		end else begin
			case (state_reg)
				eeac_pkg::EEAC_IDLE: begin
					prog_cnt_reg <= '0;
					if (wr_go) begin
						state_reg <= eeac_pkg::EEAC_PROG;
					end
				end
				eeac_pkg::EEAC_PROG: begin
					if (osc_tick) begin
						prog_cnt_reg <= prog_cnt_reg + PCNT_W'(1);
					end
					if (prog_last) begin
						state_reg <= eeac_pkg::EEAC_IDLE;
					end
				end
				default: begin
					state_reg <= eeac_pkg::EEAC_IDLE;
				end
			endcase
		end
	end

	// The byte is committed only at the end, so an abandoned write never alters the array.
	always_ff @(posedge mclk) begin
		if (prog_last) begin
			mem[addr_reg] <= wr_data_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software-visible registers.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			addr_reg <= ADDR_W'(`EEAC_RST_ADDR);
			data_reg <= `EEAC_RST_DATA;
			wr_data_reg <= `EEAC_RST_DATA;
			arm_cnt_reg <= 3'h0;
			stall_reg <= 3'h0;
			status_reg <= `EEAC_RST_EVENTS;
			mask_reg <= `EEAC_RST_EVENTS;
		end else begin
			arm_cnt_reg <= arm_cnt_next;
			stall_reg <= stall_next;
			status_reg <= status_next;
			if (addr_we) begin
				addr_reg <= pwdata[ADDR_W-1:0];
			end
			if (rd_go) begin
				data_reg <= rd_byte;
			end else if (wr_acc & sel_data) begin
				data_reg <= pwdata[7:0];
			end
			if (wr_go) begin
				wr_data_reg <= data_reg;
			end
			if (wr_acc & sel_mask) begin
				mask_reg <= pwdata[2:0];
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cpu_stall_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			cpu_stall_reg <= (stall_next != 3'h0);
			irq_reg <= |(status_next & mask_reg);
		end
	end

	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata = prdata_reg;
	assign cpu_stall = cpu_stall_reg;
	assign irq = irq_reg;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	property p_arm_needed;
		$rose(busy) |-> $past(ctrl_wr && wr_strobe_in && arm_cnt_reg != 3'h0);
	endproperty
	a_arm_needed: assert property (p_arm_needed) else $error("write began unarmed");

	property p_arm_window;
		arm_set ##1 (!ctrl_wr && !arm_set) [*4] |=> arm_cnt_reg == 3'h0;
	endproperty
	a_arm_window: assert property (p_arm_window) else $error("arm outlived window");

	property p_late_fail;
		(ctrl_wr && wr_strobe_in && arm_cnt_reg == 3'h0 && !busy) |=> !busy && status_reg.wr_fail;
	endproperty
	a_late_fail: assert property (p_late_fail) else $error("late strobe not abandoned");

	property p_flash_lock;
		$rose(busy) |-> !$past(spm_sync_reg);
	endproperty
	a_flash_lock: assert property (p_flash_lock) else $error("write during flash busy");

	property p_done_clears;
		prog_last |=> !busy && status_reg.wr_done;
	endproperty
	a_done_clears: assert property (p_done_clears) else $error("strobe not cleared");

	property p_wr_stall;
		$rose(busy) |-> cpu_stall_reg [*2] ##1 !cpu_stall_reg;
	endproperty
	a_wr_stall: assert property (p_wr_stall) else $error("write stall not two");

	property p_rd_data;
		rd_go |=> data_reg == $past(rd_byte);
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("read data not loaded");

	property p_rd_stall;
		rd_go |=> cpu_stall_reg [*4] ##1 !cpu_stall_reg;
	endproperty
	a_rd_stall: assert property (p_rd_stall) else $error("read stall not four");

	property p_addr_lock;
		busy |=> $stable(addr_reg);
	endproperty
	a_addr_lock: assert property (p_addr_lock) else $error("address moved during write");

	property p_rd_ignored;
		(busy && ctrl_wr && rd_strobe_in) |=> $stable(data_reg) && !cpu_stall_reg;
	endproperty
	a_rd_ignored: assert property (p_rd_ignored) else $error("read taken during write");

	property p_osc_count;
		$fell(busy) |-> $past(prog_cnt_reg) == PCNT_LAST && $past(osc_tick);
	endproperty
	a_osc_count: assert property (p_osc_count) else $error("write time count wrong");

endmodule

// ### dv/eeac_tb.sv
`timescale 1ns/100ps
`include "eeac_regs.svh"
module testbench;
	localparam int OSC = 8;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic self_program_busy = 1'b0;
	logic rc_osc_clk = 1'b0;
	logic cpu_stall;
	logic irq;
	logic last_err;
	logic [31:0] r;
	bit held = 1'b0;
	int num_errors = 0;
	int cmp_count = 0;
	int stall_cnt = 0;
	int osc_cnt = 0;
	int s0;
	int o0;
	bit osc_run = 1'b0;
	int osc_div = 0;

	////////////////////////////////////////////////////////////////////////////////
	eeac_top #(.ADDR_W(9), .WRITE_OSC_CYCLES(OSC)) i_dut (
		.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .self_program_busy(self_program_busy),
		.rc_osc_clk(rc_osc_clk), .cpu_stall(cpu_stall), .irq(irq)
	);

	always #10 mclk = ~mclk;
	// The oscillator waits for the first write, so the bench sees every edge that it counts.
	always @(posedge mclk) begin
		if (osc_run) begin
			if (osc_div == 2) begin
				osc_div <= 0;
				rc_osc_clk <= ~rc_osc_clk;
			end else begin
				osc_div <= osc_div + 1;
			end
		end
	end
	always @(posedge rc_osc_clk) osc_cnt++;
	always @(posedge mclk) begin
		if (cpu_stall === 1'b1) stall_cnt++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// A held transfer leaves psel up so the next setup follows at once.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			input bit keep, output logic [31:0] rv);
		int n;
		if (!held) @(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk("pready", pready, 1'b1);
		rv = prdata;
		last_err = pslverr;
		held = keep;
		if (!keep) begin
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit keep = 1'b0);
		logic [31:0] x;
		apb(1'b1, a, d, keep, x);
	endtask

	task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, 1'b0, r);
		chk(name, r, exp);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		r = 32'h2;
		while ((r[1] !== 1'b0 || r[3] !== 1'b0) && n < 200) begin
			apb(1'b0, `EEAC_OFF_CTRL, 32'h0, 1'b0, r);
			n++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		num_errors++;
		end_sim();
	end

	initial begin
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		rdc("addr", `EEAC_OFF_ADDR, 32'h0);
		rdc("data", `EEAC_OFF_DATA, 32'h0);
		rdc("status", `EEAC_OFF_STATUS, 32'h0);
		rdc("mask", `EEAC_OFF_MASK, 32'h0);
		rdc("ctrl", `EEAC_OFF_CTRL, 32'h0);
		rdc("unmapped", 8'h14, 32'h0);
		chk("slverr", last_err, 1'b1);
		wr(`EEAC_OFF_MASK, 32'h1);
		wr(`EEAC_OFF_ADDR, 32'h1FF);
		wr(`EEAC_OFF_DATA, 32'hA5);
		s0 = stall_cnt;
		wr(`EEAC_OFF_CTRL, 32'h4, 1'b1); // Arm then strobe.
		wr(`EEAC_OFF_CTRL, 32'h2); // Armed strobe.
		osc_run <= 1'b1;
		o0 = osc_cnt;
		rdc("ctrl busy", `EEAC_OFF_CTRL, 32'h2); // Busy at bit 1.
		chk("write stall", stall_cnt - s0, 2); // Write stall.
		wr(`EEAC_OFF_ADDR, 32'h010);
		wr(`EEAC_OFF_CTRL, 32'h1);
		wait_idle(); // Poll before the next read.
		chk("busy clear", r[1], 1'b0); // Hardware clears strobe.
		chk("write time", osc_cnt - o0 >= OSC && osc_cnt - o0 <= OSC + 2, 1);
		@(posedge mclk);
		chk("irq done", irq, 1'b1);
		rdc("status done", `EEAC_OFF_STATUS, 32'h1); // Read ignored.
		repeat (2) @(posedge mclk);
		chk("irq clear", irq, 1'b0);
		rdc("addr kept", `EEAC_OFF_ADDR, 32'h1FF); // Address frozen.
		wr(`EEAC_OFF_DATA, 32'h0);
		s0 = stall_cnt;
		wr(`EEAC_OFF_CTRL, 32'h1);
		rdc("read data", `EEAC_OFF_DATA, 32'hA5); // Byte at once.
		chk("read stall", stall_cnt - s0, 4); // Read stall.
		rdc("status read", `EEAC_OFF_STATUS, 32'h2);
		s0 = stall_cnt;
		wr(`EEAC_OFF_CTRL, 32'h2);
		rdc("unarmed", `EEAC_OFF_STATUS, 32'h4); // Strobe alone fails.
		wr(`EEAC_OFF_CTRL, 32'h4);
		repeat (8) @(posedge mclk);
		wr(`EEAC_OFF_CTRL, 32'h2);
		rdc("late ctrl", `EEAC_OFF_CTRL, 32'h0); // Arm timed out.
		rdc("late fail", `EEAC_OFF_STATUS, 32'h4); // Write abandoned.
		self_program_busy <= 1'b1;
		repeat (4) @(posedge mclk);
		rdc("flash ctrl", `EEAC_OFF_CTRL, 32'h8);
		wr(`EEAC_OFF_DATA, 32'h66);
		wr(`EEAC_OFF_CTRL, 32'h4, 1'b1);
		wr(`EEAC_OFF_CTRL, 32'h2);
		rdc("flash busy", `EEAC_OFF_CTRL, 32'h8); // No write.
		chk("fail stall", stall_cnt - s0, 0);
		chk("irq masked", irq, 1'b0);
		wr(`EEAC_OFF_MASK, 32'h4);
		repeat (2) @(posedge mclk);
		chk("irq fail", irq, 1'b1);
		rdc("flash fail", `EEAC_OFF_STATUS, 32'h4); // Failure flagged.
		self_program_busy <= 1'b0;
		repeat (2) @(posedge mclk);
		chk("irq off", irq, 1'b0);
		wr(`EEAC_OFF_DATA, 32'h3C); // Data before address.
		wr(`EEAC_OFF_ADDR, 32'h003);
		wait_idle(); // Strobe and flash busy read zero.
		wr(`EEAC_OFF_CTRL, 32'h4, 1'b1); // Strobe follows arm with no gap.
		wr(`EEAC_OFF_CTRL, 32'h2);
		wait_idle(); // Poll before the read.
		wr(`EEAC_OFF_DATA, 32'h0);
		wr(`EEAC_OFF_CTRL, 32'h1);
		rdc("second byte", `EEAC_OFF_DATA, 32'h3C);
		wr(`EEAC_OFF_ADDR, 32'h1FF);
		wr(`EEAC_OFF_CTRL, 32'h1);
		rdc("byte kept", `EEAC_OFF_DATA, 32'hA5); // Failed writes left it.
		rdc("status end", `EEAC_OFF_STATUS, 32'h3);
		end_sim();
	end
endmodule
